// ### qll_regs.svh
// Register map, field positions, reset values and timing counts
// for the quick link loss monitor. Assumes a 100 MHz core clock.
`ifndef QLL_REGS_SVH
`define QLL_REGS_SVH

`define QLL_ADDR_CTRL 16'h000b
`define QLL_ADDR_STAT 16'h000f
`define QLL_ADDR_CFG1 16'h0117
`define QLL_ADDR_CFG2 16'h0131

// Detector index inside the 5-bit enable and status vectors
`define QLL_D_RX 0
`define QLL_D_MLT3 1
`define QLL_D_SNR 2
`define QLL_D_NRG 3
`define QLL_D_DSCR 4
// Register bit carrying the descrambler detector
`define QLL_BIT_DSCR 10

`define QLL_CFG1_RST 16'h0000
`define QLL_CFG2_RST 16'h0000
`define QLL_CFG1_MLT3 16'h0417
`define QLL_CFG2_DSCR 6'h08

`define QLL_THR_RX 6'h20
`define QLL_THR_MLT3 6'h14
`define QLL_THR_SNR 6'h14

`define QLL_CLK_NS 10
`define QLL_WIN_NS 10000
`define QLL_WIN_CYC (`QLL_WIN_NS / `QLL_CLK_NS)
`define QLL_SYNC_WAIT 2'h2

`endif

// ### qll_pkg.sv
// Types for the quick link loss monitor.
// Assumes qll_regs.svh is on the include path.
package qll_pkg;

  typedef enum logic [1:0] {
    QLL_CAP = 2'b01,
    QLL_RUN = 2'b10
  } qll_phase_t;

  typedef struct packed {
    logic descr_lost;
    logic energy_lost;
    logic snr_cross;
    logic mlt3_err;
    logic rx_err;
  } qll_evt_t;

  typedef struct packed {
    logic basic_mode;
    logic link_drop_enable_strap;
    logic odd_nibble_strap;
    logic energy_detect_strap;
  } qll_strap_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } qll_req_t;

  typedef struct packed {
    qll_phase_t phase;
    logic [1:0] wait_cnt;
    logic por;
    qll_strap_t s1;
    qll_strap_t s2;
    qll_strap_t cap;
    logic [4:0] en;
    logic [4:0] stat;
    logic [4:0] fired;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [9:0] win;
    logic [2:0][5:0] cnt;
    logic drop;
    logic [15:0] rdata;
    logic rvalid;
  } qll_state_t;

endpackage

// ### qll_monitor.sv
// Quick link loss monitor: counts receive fault events in a fixed
// window and drops the link when an enabled detector fires.
// Assumes event inputs come from core-clock logic; straps are pins.
`include "qll_regs.svh"

module qll_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hard_rst,
  input wire logic soft_rst,
  input wire qll_pkg::qll_strap_t strap_i,
  input wire qll_pkg::qll_evt_t evt_i,
  input wire qll_pkg::qll_req_t req_i,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic link_drop
);
  import qll_pkg::*;

  localparam logic [9:0] WIN_LAST = 10'(`QLL_WIN_CYC - 1);

  qll_state_t q;
  qll_state_t d;
  logic [4:0] fire;
  logic [2:0] cnt_evt;
  logic [2:0][5:0] thr;
  logic boundary;
  logic run_ok;

  function automatic logic [4:0] strap_dflt(input qll_strap_t s);
    logic [4:0] v;
    v = '0;
    if (s.basic_mode) begin
      v[`QLL_D_RX] = 1'b1;
      v[`QLL_D_NRG] = 1'b1;
    end else if (!s.link_drop_enable_strap) begin
      v = '0;
    end else if (s.odd_nibble_strap) begin
      v[`QLL_D_RX] = 1'b1;
      v[`QLL_D_SNR] = 1'b1;
      v[`QLL_D_NRG] = 1'b1;
      v[`QLL_D_DSCR] = 1'b1;
    end else if (!s.energy_detect_strap) begin
      v[`QLL_D_RX] = 1'b1;
      v[`QLL_D_NRG] = 1'b1;
    end else begin
      v[`QLL_D_RX] = 1'b1;
    end
    return v;
  endfunction

  assign cnt_evt = {evt_i.snr_cross, evt_i.mlt3_err, evt_i.rx_err};
  assign thr[0] = `QLL_THR_RX;
  assign thr[1] = `QLL_THR_MLT3;
  assign thr[2] = `QLL_THR_SNR;
  assign boundary = (q.win == WIN_LAST);
  assign run_ok = (q.phase == QLL_RUN) && !hard_rst && !soft_rst;

  always_comb begin
    logic [5:0] base;
    d = q;
    fire = '0;
    base = '0;
    // Straps are single-bit two-level inputs, two flops deep
    d.s1 = strap_i;
    d.s2 = q.s1;
    d.drop = 1'b0;
    d.rvalid = 1'b0;
    case (q.phase)
      QLL_CAP: begin
        // Wait so that the synchroniser holds real pin levels
        if (q.wait_cnt == `QLL_SYNC_WAIT) begin
          d.cap.basic_mode = q.s2.basic_mode;
          d.cap.link_drop_enable_strap = q.s2.link_drop_enable_strap;
          d.cap.energy_detect_strap = q.s2.energy_detect_strap;
          if (q.por) begin
            d.cap.odd_nibble_strap = q.s2.odd_nibble_strap;
          end
          d.en = strap_dflt(d.cap);
          d.por = 1'b0;
          d.phase = QLL_RUN;
        end else begin
          d.wait_cnt = q.wait_cnt + 2'h1;
        end
      end
      QLL_RUN: begin
        if (hard_rst) begin
          d.phase = QLL_CAP;
          d.wait_cnt = '0;
          d.stat = '0;
          d.fired = '0;
          d.cnt = '0;
          d.win = '0;
          d.cfg1 = `QLL_CFG1_RST;
          d.cfg2 = `QLL_CFG2_RST;
        end else if (soft_rst) begin
          d.en = strap_dflt(q.cap);
          d.stat = '0;
          d.fired = '0;
          d.cnt = '0;
          d.win = '0;
          d.cfg1 = `QLL_CFG1_RST;
          d.cfg2 = `QLL_CFG2_RST;
        end else begin
          // Free-running window; an event on the boundary opens
          // the new window rather than being lost
          d.win = boundary ? '0 : q.win + 10'h001;
          for (int i = 0; i < 3; i++) begin
            base = boundary ? '0 : q.cnt[i];
            // Saturate at the threshold so a burst fires once
            if (cnt_evt[i] && base != thr[i]) begin
              d.cnt[i] = base + 6'h01;
            end else begin
              d.cnt[i] = base;
            end
          end
          fire[`QLL_D_RX] = q.en[`QLL_D_RX] && evt_i.rx_err &&
            (d.cnt[0] == `QLL_THR_RX) &&
            (q.cnt[0] != `QLL_THR_RX || boundary);
          fire[`QLL_D_MLT3] = q.en[`QLL_D_MLT3] && evt_i.mlt3_err &&
            (q.cfg1 == `QLL_CFG1_MLT3) &&
            (d.cnt[1] == `QLL_THR_MLT3) &&
            (q.cnt[1] != `QLL_THR_MLT3 || boundary);
          fire[`QLL_D_SNR] = q.en[`QLL_D_SNR] && evt_i.snr_cross &&
            (d.cnt[2] == `QLL_THR_SNR) &&
            (q.cnt[2] != `QLL_THR_SNR || boundary);
          fire[`QLL_D_NRG] = q.en[`QLL_D_NRG] &&
            evt_i.energy_lost;
          fire[`QLL_D_DSCR] = q.en[`QLL_D_DSCR] && evt_i.descr_lost &&
            (q.cfg2[5:0] == `QLL_CFG2_DSCR);
          d.fired = fire;
          // Level faults would re-drop every cycle; pulse on new ones
          d.drop = |(fire & ~q.fired);
          // Sticky cause; a new fault wins over the clearing read
          if (req_i.rd && req_i.addr == `QLL_ADDR_STAT) begin
            d.stat = fire;
          end else begin
            d.stat = q.stat | fire;
          end
          if (req_i.wr) begin
            case (req_i.addr)
              `QLL_ADDR_CTRL: begin
                d.en = {req_i.wdata[`QLL_BIT_DSCR],
                        req_i.wdata[3:0]};
              end
              `QLL_ADDR_CFG1: d.cfg1 = req_i.wdata;
              `QLL_ADDR_CFG2: d.cfg2 = req_i.wdata;
              default: d.cfg1 = d.cfg1;
            endcase
          end
        end
        if (req_i.rd) begin
          d.rvalid = 1'b1;
          case (req_i.addr)
            `QLL_ADDR_CTRL: begin
              d.rdata = {5'h00, q.en[`QLL_D_DSCR], 6'h00,
                         q.en[3:0]};
            end
            `QLL_ADDR_STAT: begin
              d.rdata = {5'h00, q.stat[`QLL_D_DSCR], 6'h00,
                         q.stat[3:0]};
            end
            `QLL_ADDR_CFG1: d.rdata = q.cfg1;
            `QLL_ADDR_CFG2: d.rdata = q.cfg2;
            default: d.rdata = 16'h0000;
          endcase
        end
      end
      default: begin
        d.phase = QLL_CAP;
        d.wait_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.phase <= QLL_CAP;
      q.por <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign rvalid = q.rvalid;
  assign link_drop = q.drop;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_strap_low_off: assert property (
    ce && q.phase == QLL_CAP && q.wait_cnt == `QLL_SYNC_WAIT &&
    !q.s2.basic_mode && !q.s2.link_drop_enable_strap
    |=> q.en == 5'h00)
    else $error("drop strap low left a detector enabled");

  a_basic_dflt: assert property (
    ce && q.phase == QLL_CAP && q.wait_cnt == `QLL_SYNC_WAIT &&
    q.s2.basic_mode
    |=> q.en == 5'h09 && q.phase == QLL_RUN)
    else $error("basic mode default enables wrong");

  a_odd_nib_keep: assert property (
    q.phase == QLL_CAP && !q.por
    |=> $stable(q.cap.odd_nibble_strap))
    else $error("odd nibble strap recaptured after hard reset");

  a_soft_reload: assert property (
    ce && q.phase == QLL_RUN && soft_rst && !hard_rst
    |=> q.en == strap_dflt(q.cap) && $stable(q.cap))
    else $error("soft reset did not reload strap defaults");

  a_ctrl_write: assert property (
    ce && run_ok && req_i.wr && req_i.addr == `QLL_ADDR_CTRL
    |=> q.en == {$past(req_i.wdata[10]), $past(req_i.wdata[3:0])})
    else $error("control write did not set detector enables");

  a_win_bound: assert property (
    q.win <= WIN_LAST && q.cnt[0] <= `QLL_THR_RX &&
    q.cnt[1] <= `QLL_THR_MLT3 && q.cnt[2] <= `QLL_THR_SNR)
    else $error("window or event count out of range");

  a_nrg_drop: assert property (
    ce && run_ok && q.en[`QLL_D_NRG] && evt_i.energy_lost &&
    !q.fired[`QLL_D_NRG]
    |=> link_drop && q.stat[`QLL_D_NRG])
    else $error("energy loss did not drop the link");

  a_mlt3_gate: assert property (
    q.fired[`QLL_D_MLT3] |-> q.cfg1 == `QLL_CFG1_MLT3 &&
    q.cnt[1] == `QLL_THR_MLT3)
    else $error("MLT3 fault without config or count");

  a_dscr_gate: assert property (
    q.fired[`QLL_D_DSCR] |-> q.cfg2[5:0] == `QLL_CFG2_DSCR)
    else $error("descrambler fault without config");

  a_rx_count: assert property (
    q.fired[`QLL_D_RX] |-> q.cnt[0] == `QLL_THR_RX)
    else $error("rx error fault below 32 events");

  a_stat_sticky: assert property (
    ce && run_ok && q.stat[`QLL_D_RX] &&
    !(req_i.rd && req_i.addr == `QLL_ADDR_STAT)
    |=> q.stat[`QLL_D_RX])
    else $error("status bit lost without a read");

  a_drop_cause: assert property (
    link_drop |-> q.fired != 5'h00 && q.stat != 5'h00)
    else $error("link drop without recorded cause");

  // A low clock enable must hold every bit of state, counters included
  a_ce_freeze: assert property (
    !ce |=> $stable(q))
    else $error("state moved while clock enable was low");

  a_cap_quiet: assert property (
    ce && q.phase == QLL_CAP
    |=> !rvalid && !link_drop)
    else $error("answer or drop during strap capture");

  a_rx_fire: assert property (
    ce && run_ok && q.en[`QLL_D_RX] && evt_i.rx_err && !boundary &&
    q.cnt[0] == `QLL_THR_RX - 6'h01
    |=> link_drop && q.stat[`QLL_D_RX])
    else $error("32nd rx error in a window did not drop the link");

  a_snr_fire: assert property (
    ce && run_ok && q.en[`QLL_D_SNR] && evt_i.snr_cross && !boundary &&
    q.cnt[2] == `QLL_THR_SNR - 6'h01
    |=> link_drop && q.stat[`QLL_D_SNR])
    else $error("20th SNR crossing in a window did not drop the link");

  a_dscr_fire: assert property (
    ce && run_ok && q.en[`QLL_D_DSCR] && evt_i.descr_lost &&
    q.cfg2[5:0] == `QLL_CFG2_DSCR && !q.fired[`QLL_D_DSCR]
    |=> link_drop && q.stat[`QLL_D_DSCR])
    else $error("descrambler lock loss did not drop the link");

  a_soft_clear: assert property (
    ce && q.phase == QLL_RUN && soft_rst && !hard_rst
    |=> q.cfg1 == `QLL_CFG1_RST && q.stat == 5'h00)
    else $error("soft reset left config or status set");

  c_rx_drop: cover property (link_drop && q.fired[`QLL_D_RX]);
  c_dscr_drop: cover property (link_drop && q.fired[`QLL_D_DSCR]);
  c_nrg_drop: cover property (link_drop && q.fired[`QLL_D_NRG]);
  c_soft_rst: cover property (ce && run_ok ##1 ce && soft_rst);
  c_hard_cap: cover property (q.phase == QLL_CAP && !q.por);

endmodule // qll_monitor

// ### qll_peer.sv
// Far end of the receive path: emits bursts of fault events.
// Assumes the bench holds pat and len steady while a burst runs.
module qll_peer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic slow,
  input wire qll_pkg::qll_evt_t pat,
  input wire logic [7:0] len,
  output qll_pkg::qll_evt_t evt,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  import qll_pkg::*;
  logic [7:0] left_q;
  logic gap_q;
  assign busy = left_q != 8'h00;
  // Quiet line shows no fault; a slow peer idles one cycle per event
  assign evt = (busy && !gap_q) ? pat : '0;
  always_ff @(posedge clk) begin
    if (!rst_n || go) begin
      left_q <= rst_n ? len : 8'h00;
      gap_q <= 1'b0;
    end else if (busy) begin
      gap_q <= slow && !gap_q;
      if (!gap_q) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule // qll_peer

// ### tb_top.sv
// Self-checking bench for the quick link loss monitor.
// Assumes qll_regs.svh on the include path and a 100 MHz clock.
`include "qll_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import qll_pkg::*;
  logic clk, rst_n, ce, hard_rst, soft_rst, rvalid, link_drop;
  logic go, slow, busy;
  logic [15:0] rdata;
  logic [7:0] len;
  qll_strap_t strap;
  qll_req_t req;
  qll_evt_t evt, pat;
  int fails, checked;

  qll_monitor DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .hard_rst(hard_rst),
    .soft_rst(soft_rst), .strap_i(strap), .evt_i(evt), .req_i(req),
    .rdata(rdata), .rvalid(rvalid), .link_drop(link_drop));
  qll_peer link_peer (.clk(clk), .rst_n(rst_n), .go(go), .slow(slow),
    .pat(pat), .len(len), .evt(evt), .busy(busy));

  always #5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // An idle edge after each access keeps req from being set twice
  // in one time step when calls follow each other
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req = {1'b1, 1'b0, a, d};
    cyc(1);
    req = '0;
    cyc(1);
  endtask

  // Read answer is registered on the same edge that samples the request
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    req = {1'b0, 1'b1, a, 16'h0000};
    cyc(1);
    req = '0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, exp);
    cyc(1);
  endtask

  // Kind 0 power-on, 1 hard, 2 soft; straps settle before the pulse.
  // Power-on holds the synchroniser in reset, so no settling is needed.
  task automatic boot(input qll_strap_t s, input int kind);
    strap = s;
    if (kind == 0) begin
      rst_n = 1'b0;
    end else begin
      cyc(3);
    end
    if (kind == 1) hard_rst = 1'b1;
    else if (kind == 2) soft_rst = 1'b1;
    cyc(kind == 0 ? 5 : 1);
    rst_n = 1'b1;
    hard_rst = 1'b0;
    soft_rst = 1'b0;
    cyc(5);
  endtask

  // Hard reset restarts the window so a burst never straddles a boundary
  task automatic fault(input logic [15:0] en, input logic [15:0] c1,
      input logic [15:0] c2, input qll_evt_t p, input logic [7:0] n,
      input logic sl, input logic [15:0] drops, input logic [15:0] st);
    int k;
    k = 0;
    boot(4'b0100, 1);
    wr(`QLL_ADDR_CTRL, en);
    wr(`QLL_ADDR_CFG1, c1);
    wr(`QLL_ADDR_CFG2, c2);
    pat = p;
    slow = sl;
    len = n;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    repeat (2 * n + 4) begin
      if (link_drop === 1'b1) k++;
      cyc(1);
    end
    chk(16'(k), drops);
    rd(`QLL_ADDR_STAT, st);
    rd(`QLL_ADDR_STAT, 16'h0000);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    ce = 1'b1;
    hard_rst = 1'b0;
    soft_rst = 1'b0;
    req = '0;
    go = 1'b0;
    slow = 1'b0;
    pat = '0;
    len = 8'h00;
    fails = 0;
    checked = 0;
    boot(4'b0110, 0);
    rd(`QLL_ADDR_CTRL, 16'h040d);
    boot(4'b0101, 1);
    rd(`QLL_ADDR_CTRL, 16'h040d);
    boot(4'b0101, 0);
    rd(`QLL_ADDR_CTRL, 16'h0001);
    boot(4'b0100, 2);
    rd(`QLL_ADDR_CTRL, 16'h0001);
    boot(4'b0100, 1);
    rd(`QLL_ADDR_CTRL, 16'h0009);
    boot(4'b0000, 1);
    rd(`QLL_ADDR_CTRL, 16'h0000);
    boot(4'b1000, 1);
    rd(`QLL_ADDR_CTRL, 16'h0009);
    // A write while the clock enable is low must not land
    ce = 1'b0;
    wr(`QLL_ADDR_CTRL, 16'h0000);
    ce = 1'b1;
    rd(`QLL_ADDR_CTRL, 16'h0009);
    wr(`QLL_ADDR_CTRL, 16'hffff);
    rd(`QLL_ADDR_CTRL, 16'h040f);
    wr(`QLL_ADDR_CFG1, 16'h0417);
    rd(`QLL_ADDR_CFG1, 16'h0417);
    wr(`QLL_ADDR_CFG2, 16'h0008);
    rd(`QLL_ADDR_CFG2, 16'h0008);
    boot(4'b1000, 2);
    rd(`QLL_ADDR_CTRL, 16'h0009);
    rd(`QLL_ADDR_CFG1, 16'h0000);
    wr(`QLL_ADDR_STAT, 16'hffff);
    rd(`QLL_ADDR_STAT, 16'h0000);
    rd(16'h0010, 16'h0000);
    fault(16'h0001, 0, 0, 5'b00001, 31, 0, 0, 16'h0000);
    fault(16'h0001, 0, 0, 5'b00001, 32, 1, 1, 16'h0001);
    fault(16'h0002, 0, 0, 5'b00010, 20, 0, 0, 16'h0000);
    fault(16'h0002, 16'h0417, 0, 5'b00010, 19, 0, 0, 0);
    fault(16'h0002, 16'h0417, 0, 5'b00010, 20, 1, 1, 2);
    fault(16'h0004, 0, 0, 5'b00100, 19, 1, 0, 16'h0000);
    fault(16'h0004, 0, 0, 5'b00100, 20, 0, 1, 16'h0004);
    fault(16'h0008, 0, 0, 5'b01000, 2, 1, 2, 16'h0008);
    fault(16'h0001, 0, 0, 5'b01000, 1, 0, 0, 16'h0000);
    fault(16'h0400, 0, 16'h0008, 5'b10000, 1, 0, 1, 16'h0400);
    fault(16'h0400, 0, 16'h0000, 5'b10000, 1, 0, 0, 16'h0000);
    fault(16'h040f, 0, 16'h0008, 5'b11000, 1, 0, 1, 16'h0408);
    end_of_test();
  end
endmodule // tb_top
